// ===== design/drop_side_vt_alarm_pkg.sv
// constants for the drop side VT/TU alarm status block
// assumes a 50 MHz clock and a classic Wishbone slave with 32-bit data
package drop_side_vt_alarm_pkg;

    localparam int N_CHAN = 8;
    localparam int CH_W   = 3;
    localparam int N_PATH = 7;
    localparam int N_PTR  = 5;
    localparam int CNT_W  = 4;
    localparam int IDX_W  = 9;
    localparam int SEC_W  = 26;

    // path alarm bit positions
    localparam int P_VCAIS = 6;
    localparam int P_UNEQ  = 5;
    localparam int P_RDIC  = 4;
    localparam int P_RDIP  = 3;
    localparam int P_RDIS  = 2;
    localparam int P_SLER  = 1;
    localparam int P_RFI   = 0;
    // pointer and fifo alarm bit positions
    localparam int Q_FIFO = 4;
    localparam int Q_AIS  = 3;
    localparam int Q_LOP  = 2;
    localparam int Q_NDF  = 1;
    localparam int Q_SIZE = 0;

    // register indices; byte address is four times the index plus 2048 times the channel
    localparam logic [IDX_W-1:0] IDX_CFG       = 9'h010;
    localparam logic [IDX_W-1:0] IDX_PATH_MASK = 9'h013;
    localparam logic [IDX_W-1:0] IDX_PTR_MASK  = 9'h014;
    localparam logic [IDX_W-1:0] IDX_PATH_LIVE = 9'h110;
    localparam logic [IDX_W-1:0] IDX_PTR_LIVE  = 9'h111;
    localparam logic [IDX_W-1:0] IDX_PATH_LAT  = 9'h120;
    localparam logic [IDX_W-1:0] IDX_PTR_LAT   = 9'h121;
    localparam logic [IDX_W-1:0] IDX_PATH_SEC  = 9'h130;
    localparam logic [IDX_W-1:0] IDX_PTR_SEC   = 9'h131;
    localparam logic [IDX_W-1:0] IDX_PATH_PSEC = 9'h140;
    localparam logic [IDX_W-1:0] IDX_PTR_PSEC  = 9'h141;

    // config register fields
    localparam int CFG_LABEL_LSB = 0;
    localparam int CFG_TRANS_LSB = 3;
    localparam int CFG_PERSIST   = 5;
    localparam int CFG_SINGLE    = 6;
    localparam int CFG_AIS_EN    = 7;
    localparam logic [7:0] CFG_RESET  = 8'h01;
    localparam logic [7:0] MASK_RESET = 8'h00;

    localparam logic [1:0] TRANS_RISE = 2'h0;
    localparam logic [1:0] TRANS_FALL = 2'h1;

    localparam logic [2:0] LABEL_AIS    = 3'h7;
    localparam logic [2:0] LABEL_UNEQ   = 3'h0;
    localparam logic [2:0] ERDI_PAYLOAD = 3'h2;
    localparam logic [2:0] ERDI_SERVER  = 3'h5;
    localparam logic [2:0] ERDI_CONN    = 3'h6;

    localparam logic [CNT_W-1:0] LABEL_PERSIST = 4'h5;
    localparam logic [CNT_W-1:0] RFI_PERSIST   = 4'h5;
    localparam logic [CNT_W-1:0] RDI_PERSIST_S = 4'h5;
    localparam logic [CNT_W-1:0] RDI_PERSIST_L = 4'hA;

    localparam logic [1:0] SIZE_DS1   = 2'h3;
    localparam logic [1:0] SIZE_E1    = 2'h2;
    localparam logic [9:0] PTR_MAX_DS1 = 10'h067;
    localparam logic [9:0] PTR_MAX_E1  = 10'h08B;
    localparam logic [3:0] NDF_SET     = 4'h9;
    localparam logic [3:0] NDF_NEAR_A  = 4'h1;
    localparam logic [3:0] NDF_NEAR_B  = 4'hD;
    localparam logic [3:0] NDF_NEAR_C  = 4'hB;
    localparam logic [3:0] NDF_NEAR_D  = 4'h8;

    localparam logic [1:0] AIS_MF = 2'h2;

    localparam int CLK_PERIOD_NS = 20;
    localparam int ONE_SEC_NS    = 1_000_000_000;
    localparam int ONE_SEC_CYCLES = ONE_SEC_NS / CLK_PERIOD_NS;

endpackage

// ===== design/drop_side_vt_alarm_status.sv
// drop side VT/TU alarm detection and status registers, eight channels
// assumes overhead strobes and pointer states come from logic on clock
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/10ps
module drop_side_vt_alarm_status
    import drop_side_vt_alarm_pkg::*;
#(
    parameter int SEC_CYCLES = ONE_SEC_CYCLES
)
(
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [15:0]       wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              v5_valid,
    input  wire logic [CH_W-1:0]   v5_chan,
    input  wire logic [7:0]        v5_byte,
    input  wire logic              erdi_valid,
    input  wire logic [CH_W-1:0]   erdi_chan,
    input  wire logic [2:0]        erdi_code,
    input  wire logic              v1_valid,
    input  wire logic [CH_W-1:0]   v1_chan,
    input  wire logic [7:0]        v1_byte,
    input  wire logic [7:0]        v2_byte,
    input  wire logic [N_CHAN-1:0] ptr_ais,
    input  wire logic [N_CHAN-1:0] ptr_lop,
    input  wire logic [N_CHAN-1:0] fifo_overflow,
    input  wire logic [N_CHAN-1:0] fifo_underflow,
    output logic                   irq,
    output logic      [N_CHAN-1:0] line_ais,
    output logic      [N_CHAN-1:0] fifo_reset
);

    typedef struct packed {
        logic [N_CHAN-1:0][N_PATH-1:0]            path_live;
        logic [N_CHAN-1:0][N_PATH-1:0]            path_lat;
        logic [N_CHAN-1:0][N_PATH-1:0]            path_sec;
        logic [N_CHAN-1:0][N_PATH-1:0]            path_psec;
        logic [N_CHAN-1:0][N_PATH-1:0]            path_mask;
        logic [N_CHAN-1:0][N_PTR-1:0]             ptr_live;
        logic [N_CHAN-1:0][N_PTR-1:0]             ptr_lat;
        logic [N_CHAN-1:0][N_PTR-1:0]             ptr_sec;
        logic [N_CHAN-1:0][N_PTR-1:0]             ptr_psec;
        logic [N_CHAN-1:0][N_PTR-1:0]             ptr_mask;
        logic [N_CHAN-1:0][N_PATH-1:0][CNT_W-1:0] cnt;
        logic [N_CHAN-1:0][1:0]                   mf_cnt;
        logic [N_CHAN-1:0][7:0]                   cfg;
        logic [SEC_W-1:0]                         sec_cnt;
        logic                                     ack;
        logic [7:0]                               dat;
        logic                                     irq;
        logic [N_CHAN-1:0]                        line_ais;
        logic [N_CHAN-1:0]                        fifo_rst;
    } state_t;

    state_t state_ff;
    state_t nxt_state;

    // returns {new live, new count}
    function automatic logic [CNT_W:0] persist(
        input logic             live,
        input logic [CNT_W-1:0] cnt,
        input logic             cond,
        input logic [CNT_W-1:0] need
    );
        logic [CNT_W-1:0] inc;
        inc = CNT_W'(cnt + 1'b1);
        if (cond == live)
            persist = {live, {CNT_W{1'b0}}};
        else if (inc >= need)
            persist = {cond, {CNT_W{1'b0}}};
        else
            persist = {live, inc};
    endfunction

    function automatic logic [N_PATH-1:0] edge_set(
        input logic [N_PATH-1:0] old_v,
        input logic [N_PATH-1:0] new_v,
        input logic [1:0]        sel
    );
        logic [N_PATH-1:0] chg;
        chg = old_v ^ new_v;
        case (sel)
            TRANS_RISE: edge_set = chg & new_v;
            TRANS_FALL: edge_set = chg & ~new_v;
            default:    edge_set = chg;
        endcase
    endfunction

    always_comb
    begin
        logic              req;
        logic              done;
        logic              wr_ok;
        logic [CH_W-1:0]   a_ch;
        logic [IDX_W-1:0]  a_idx;
        logic              a_ok;
        logic              sec_tick;
        logic [2:0]        lbl;
        logic [CNT_W-1:0]  rdi_need;
        logic [CNT_W:0]    r;
        logic [9:0]        ptr_val;
        logic              size_bad;
        logic              ndf_pat;
        logic              ptr_ok;
        logic [N_PATH-1:0] p_old;
        logic [N_PTR-1:0]  q_old;
        logic [N_PATH-1:0] p_clr;
        logic [N_PTR-1:0]  q_clr;
        logic [1:0]        tsel;
        logic [1:0]        mf_inc;
        logic              any_irq;
        logic [7:0]        rd;
        req      = wb_cyc_i & wb_stb_i;
        done     = req & state_ff.ack;
        wr_ok    = done & wb_we_i & wb_sel_i[0];
        a_ch     = wb_adr_i[13:11];
        a_idx    = wb_adr_i[10:2];
        a_ok     = (wb_adr_i[15:14] == 2'h0);
        sec_tick = (state_ff.sec_cnt == SEC_W'(SEC_CYCLES - 1));
        lbl      = v5_byte[3:1];
        rdi_need = RDI_PERSIST_S;
        r        = '0;
        ptr_val  = {v1_byte[1:0], v2_byte};
        size_bad = 1'b0;
        ndf_pat  = 1'b0;
        ptr_ok   = 1'b0;
        p_old    = '0;
        q_old    = '0;
        p_clr    = '0;
        q_clr    = '0;
        tsel     = TRANS_RISE;
        mf_inc   = 2'h0;
        any_irq  = 1'b0;
        rd       = 8'h00;
        nxt_state = state_ff;

        nxt_state.sec_cnt = sec_tick ? '0 : SEC_W'(state_ff.sec_cnt + 1'b1);
        nxt_state.ack      = req & ~state_ff.ack;
        nxt_state.fifo_rst = '0;

        for (int c = 0; c < N_CHAN; c++)
        begin
            p_old = state_ff.path_live[c];
            q_old = state_ff.ptr_live[c];
            tsel  = state_ff.cfg[c][CFG_TRANS_LSB +: 2];
            rdi_need = state_ff.cfg[c][CFG_PERSIST] ? RDI_PERSIST_L
                                                    : RDI_PERSIST_S;

            if (v5_valid && v5_chan == CH_W'(c))
            begin
                r = persist(p_old[P_VCAIS], state_ff.cnt[c][P_VCAIS],
                            lbl == LABEL_AIS, LABEL_PERSIST);
                {nxt_state.path_live[c][P_VCAIS],
                 nxt_state.cnt[c][P_VCAIS]} = r;
                r = persist(p_old[P_UNEQ], state_ff.cnt[c][P_UNEQ],
                            lbl == LABEL_UNEQ, LABEL_PERSIST);
                {nxt_state.path_live[c][P_UNEQ],
                 nxt_state.cnt[c][P_UNEQ]} = r;
                r = persist(p_old[P_SLER], state_ff.cnt[c][P_SLER],
                            lbl != state_ff.cfg[c][CFG_LABEL_LSB +: 3],
                            LABEL_PERSIST);
                {nxt_state.path_live[c][P_SLER],
                 nxt_state.cnt[c][P_SLER]} = r;
                r = persist(p_old[P_RFI], state_ff.cnt[c][P_RFI],
                            v5_byte[4], RFI_PERSIST);
                {nxt_state.path_live[c][P_RFI],
                 nxt_state.cnt[c][P_RFI]} = r;
                // single-bit mode: V5 bit 8 alone, enhanced kinds decay
                if (state_ff.cfg[c][CFG_SINGLE])
                begin
                    r = persist(p_old[P_RDIS], state_ff.cnt[c][P_RDIS],
                                v5_byte[0], rdi_need);
                    {nxt_state.path_live[c][P_RDIS],
                     nxt_state.cnt[c][P_RDIS]} = r;
                    r = persist(p_old[P_RDIC], state_ff.cnt[c][P_RDIC],
                                1'b0, rdi_need);
                    {nxt_state.path_live[c][P_RDIC],
                     nxt_state.cnt[c][P_RDIC]} = r;
                    r = persist(p_old[P_RDIP], state_ff.cnt[c][P_RDIP],
                                1'b0, rdi_need);
                    {nxt_state.path_live[c][P_RDIP],
                     nxt_state.cnt[c][P_RDIP]} = r;
                end
            end

            if (erdi_valid && erdi_chan == CH_W'(c) &&
                !state_ff.cfg[c][CFG_SINGLE])
            begin
                r = persist(p_old[P_RDIC], state_ff.cnt[c][P_RDIC],
                            erdi_code == ERDI_CONN, rdi_need);
                {nxt_state.path_live[c][P_RDIC],
                 nxt_state.cnt[c][P_RDIC]} = r;
                r = persist(p_old[P_RDIP], state_ff.cnt[c][P_RDIP],
                            erdi_code == ERDI_PAYLOAD, rdi_need);
                {nxt_state.path_live[c][P_RDIP],
                 nxt_state.cnt[c][P_RDIP]} = r;
                r = persist(p_old[P_RDIS], state_ff.cnt[c][P_RDIS],
                            erdi_code == ERDI_SERVER, rdi_need);
                {nxt_state.path_live[c][P_RDIS],
                 nxt_state.cnt[c][P_RDIS]} = r;
            end

            if (v1_valid && v1_chan == CH_W'(c))
            begin
                size_bad = (v1_byte[3:2] != SIZE_DS1) &&
                           (v1_byte[3:2] != SIZE_E1);
                ndf_pat  = (v1_byte[7:4] == NDF_SET) ||
                           (v1_byte[7:4] == NDF_NEAR_A) ||
                           (v1_byte[7:4] == NDF_NEAR_B) ||
                           (v1_byte[7:4] == NDF_NEAR_C) ||
                           (v1_byte[7:4] == NDF_NEAR_D);
                ptr_ok   = (v1_byte[3:2] == SIZE_DS1) ?
                           (ptr_val <= PTR_MAX_DS1) :
                           (ptr_val <= PTR_MAX_E1);
                nxt_state.ptr_live[c][Q_SIZE] = size_bad;
                nxt_state.ptr_live[c][Q_NDF] =
                    ndf_pat & ~size_bad & ptr_ok;
            end
            nxt_state.ptr_live[c][Q_AIS] = ptr_ais[c];
            nxt_state.ptr_live[c][Q_LOP] = ptr_lop[c];

            // a new fifo error restarts the AIS window
            mf_inc = 2'(state_ff.mf_cnt[c] + 1'b1);
            if (fifo_overflow[c] | fifo_underflow[c])
            begin
                nxt_state.ptr_live[c][Q_FIFO] = 1'b1;
                nxt_state.fifo_rst[c]         = 1'b1;
                nxt_state.mf_cnt[c]           = 2'h0;
            end
            else if (q_old[Q_FIFO] && v5_valid && v5_chan == CH_W'(c))
            begin
                nxt_state.mf_cnt[c] = mf_inc;
                if (mf_inc == AIS_MF)
                    nxt_state.ptr_live[c][Q_FIFO] = 1'b0;
            end
            nxt_state.line_ais[c] = nxt_state.ptr_live[c][Q_FIFO] &
                                    state_ff.cfg[c][CFG_AIS_EN];

            // read clear or write-one clear; a new edge always wins
            p_clr = '0;
            q_clr = '0;
            if (a_ok && a_ch == CH_W'(c) && done)
            begin
                if (a_idx == IDX_PATH_LAT)
                    p_clr = wb_we_i ? (wb_sel_i[0] ? wb_dat_i[N_PATH-1:0]
                                                    : '0)
                                    : '1;
                if (a_idx == IDX_PTR_LAT)
                    q_clr = wb_we_i ? (wb_sel_i[0] ? wb_dat_i[N_PTR-1:0]
                                                    : '0)
                                    : '1;
            end
            nxt_state.path_lat[c] = (state_ff.path_lat[c] & ~p_clr) |
                edge_set(p_old, nxt_state.path_live[c], tsel);
            nxt_state.ptr_lat[c] = (state_ff.ptr_lat[c] & ~q_clr) |
                N_PTR'(edge_set(N_PATH'(q_old),
                                N_PATH'(nxt_state.ptr_live[c]), tsel));

            // one-second view gathers any live time within the second
            if (sec_tick)
            begin
                nxt_state.path_psec[c] = state_ff.path_sec[c] |
                                         state_ff.path_live[c];
                nxt_state.ptr_psec[c]  = state_ff.ptr_sec[c] |
                                         state_ff.ptr_live[c];
                nxt_state.path_sec[c]  = nxt_state.path_live[c];
                nxt_state.ptr_sec[c]   = nxt_state.ptr_live[c];
            end
            else
            begin
                nxt_state.path_sec[c] = state_ff.path_sec[c] |
                                        nxt_state.path_live[c];
                nxt_state.ptr_sec[c]  = state_ff.ptr_sec[c] |
                                        nxt_state.ptr_live[c];
            end

            if (wr_ok && a_ok && a_ch == CH_W'(c))
            begin
                if (a_idx == IDX_CFG)
                    nxt_state.cfg[c] = wb_dat_i[7:0];
                if (a_idx == IDX_PATH_MASK)
                    nxt_state.path_mask[c] = wb_dat_i[N_PATH-1:0];
                if (a_idx == IDX_PTR_MASK)
                    nxt_state.ptr_mask[c] = wb_dat_i[N_PTR-1:0];
            end

            any_irq = any_irq |
                (|(nxt_state.path_lat[c] & nxt_state.path_mask[c])) |
                (|(nxt_state.ptr_lat[c] & nxt_state.ptr_mask[c]));
        end
        nxt_state.irq = any_irq;

        // read data is captured before any read clear lands
        if (a_ok)
        begin
            case (a_idx)
                IDX_CFG:       rd = state_ff.cfg[a_ch];
                IDX_PATH_MASK: rd = {1'b0, state_ff.path_mask[a_ch]};
                IDX_PTR_MASK:  rd = {3'b0, state_ff.ptr_mask[a_ch]};
                IDX_PATH_LIVE: rd = {1'b0, state_ff.path_live[a_ch]};
                IDX_PTR_LIVE:  rd = {3'b0, state_ff.ptr_live[a_ch]};
                IDX_PATH_LAT:  rd = {1'b0, state_ff.path_lat[a_ch]};
                IDX_PTR_LAT:   rd = {3'b0, state_ff.ptr_lat[a_ch]};
                IDX_PATH_SEC:  rd = {1'b0, state_ff.path_sec[a_ch]};
                IDX_PTR_SEC:   rd = {3'b0, state_ff.ptr_sec[a_ch]};
                IDX_PATH_PSEC: rd = {1'b0, state_ff.path_psec[a_ch]};
                IDX_PTR_PSEC:  rd = {3'b0, state_ff.ptr_psec[a_ch]};
                default:       rd = 8'h00;
            endcase
        end
        if (req && !state_ff.ack && !wb_we_i)
            nxt_state.dat = rd;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= '0;
            for (int c = 0; c < N_CHAN; c++)
            begin
                state_ff.cfg[c]       <= CFG_RESET;
                state_ff.path_mask[c] <= MASK_RESET[N_PATH-1:0];
                state_ff.ptr_mask[c]  <= MASK_RESET[N_PTR-1:0];
            end
        end
        else
            state_ff <= nxt_state;
    end

    assign wb_dat_o   = {24'h00_0000, state_ff.dat};
    assign wb_ack_o   = state_ff.ack;
    assign irq        = state_ff.irq;
    assign line_ais   = state_ff.line_ais;
    assign fifo_reset = state_ff.fifo_rst;

endmodule

// ===== tb/drop_side_vt_alarm_props.sv
// port assertions for the alarm status block
// assumes one clock domain; bound from the bench
`timescale 1ns/10ps
module drop_side_vt_alarm_props
    import drop_side_vt_alarm_pkg::*;
(
    input wire logic              clock,
    input wire logic              arst_n,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic              v5_valid,
    input wire logic [N_CHAN-1:0] fifo_overflow,
    input wire logic [N_CHAN-1:0] fifo_underflow,
    input wire logic              irq,
    input wire logic [N_CHAN-1:0] line_ais,
    input wire logic [N_CHAN-1:0] fifo_reset
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence taken_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence answer_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    bus_answer_a: assert property (taken_s |=> answer_s)
        else $error("request not answered");
    bus_quiet_a: assert property (
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("stray ack");
    read_width_a: assert property (
        wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper data bits set");
    data_hold_a: assert property (
        $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
        else $error("read data moved");
    fifo_reset_a: assert property (
        fifo_reset == $past(fifo_overflow | fifo_underflow))
        else $error("bad fifo reset");
    ais_rise_a: assert property (
        (line_ais & ~$past(line_ais)) != 0
            |-> fifo_reset != 0 || $past(wb_ack_o && wb_we_i, 2))
        else $error("line ais without fifo error");
    ais_end_a: assert property (
        (~line_ais & $past(line_ais)) != 0
            |-> $past(v5_valid) || $past(wb_ack_o && wb_we_i, 2))
        else $error("line ais ended off a multiframe");
    irq_clear_a: assert property (
        $fell(irq) |-> $past(wb_ack_o))
        else $error("irq fell without access");
endmodule

// ===== tb/drop_bus_model.sv
// far-side drop bus model: overhead, pointer and fifo events
// assumes calls start right after a rising clock edge
`timescale 1ns/10ps
module drop_bus_model
    import drop_side_vt_alarm_pkg::*;
(
    input  wire logic              clock,
    output logic                   v5_valid,
    output logic      [CH_W-1:0]   v5_chan,
    output logic      [7:0]        v5_byte,
    output logic                   erdi_valid,
    output logic      [CH_W-1:0]   erdi_chan,
    output logic      [2:0]        erdi_code,
    output logic                   v1_valid,
    output logic      [CH_W-1:0]   v1_chan,
    output logic      [7:0]        v1_byte,
    output logic      [7:0]        v2_byte,
    output logic      [N_CHAN-1:0] ptr_ais,
    output logic      [N_CHAN-1:0] ptr_lop,
    output logic      [N_CHAN-1:0] fifo_overflow,
    output logic      [N_CHAN-1:0] fifo_underflow
);
    initial
    begin
        {v5_valid, v5_chan, v5_byte, erdi_valid, erdi_chan} = '0;
        {erdi_code, v1_valid, v1_chan, v1_byte, v2_byte} = '0;
        {ptr_ais, ptr_lop, fifo_overflow, fifo_underflow} = '0;
    end
    // k: 0 path byte, 1 enhanced rdi code, 2 pointer bytes
    task automatic strobe(input int k, input logic [2:0] ch,
                          input logic [7:0] a, input logic [7:0] b);
        @(posedge clock);
        v5_valid <= (k == 0);
        erdi_valid <= (k == 1);
        v1_valid <= (k == 2);
        {v5_chan, erdi_chan, v1_chan} <= {3{ch}};
        {v5_byte, v1_byte, v2_byte, erdi_code} <= {a, a, b, a[2:0]};
        @(posedge clock);
        {v5_valid, erdi_valid, v1_valid} <= 3'h0;
        // stale data inverted so a late sample cannot pass by luck
        {v5_byte, v1_byte, v2_byte, erdi_code} <= ~{a, a, b, a[2:0]};
    endtask
    task automatic ptr_levels(input logic [7:0] a, input logic [7:0] l);
        @(posedge clock);
        ptr_ais <= a;
        ptr_lop <= l;
    endtask
    task automatic fifo_event(input logic [2:0] ch, input logic under);
        @(posedge clock);
        fifo_overflow[ch] <= !under;
        fifo_underflow[ch] <= under;
        @(posedge clock);
        {fifo_overflow, fifo_underflow} <= '0;
    endtask
endmodule

// ===== tb/drop_side_vt_alarm_status_tb.sv
// self-checking bench for the alarm status block
// assumes model and checker files compiled first
`timescale 1ns/10ps
module drop_side_vt_alarm_status_tb;
    import drop_side_vt_alarm_pkg::*;
    localparam int SEC = 50;
    logic              clock, arst_n, irq;
    logic              wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [15:0]       wb_adr_i;
    logic [3:0]        wb_sel_i;
    logic [31:0]       wb_dat_i, wb_dat_o, rdata;
    logic              v5_valid, erdi_valid, v1_valid;
    logic [CH_W-1:0]   v5_chan, erdi_chan, v1_chan, ch, want, lab;
    logic [7:0]        v5_byte, v1_byte, v2_byte, e, pa, pl;
    logic [2:0]        erdi_code;
    logic [N_CHAN-1:0] ptr_ais, ptr_lop, fifo_overflow, fifo_underflow;
    logic [N_CHAN-1:0] line_ais, fifo_reset;
    logic [1:0]        trans, sz;
    logic [3:0]        nib;
    logic [9:0]        ptr;
    logic [2:0]        codes [3] = '{ERDI_CONN, ERDI_PAYLOAD, ERDI_SERVER};
    logic [3:0]        nibs [6] = '{4'h9, 4'h1, 4'hD, 4'hB, 4'h8, 4'h6};
    int                seed = 22550;
    int                error_cnt = 0;
    int                checked = 0;

    drop_side_vt_alarm_status #(.SEC_CYCLES(SEC)) dut (.*);
    drop_bus_model mdl (.*);

    function automatic logic [7:0] path_exp(input logic [2:0] l,
                                            input logic [2:0] w);
        return {1'b0, l == LABEL_AIS, l == LABEL_UNEQ, 3'h0, l != w, 1'b0};
    endfunction
    function automatic logic [7:0] ptr_exp(input logic [3:0] n,
        input logic [1:0] s, input logic a, input logic l);
        logic ok;
        ok = (s == SIZE_DS1) || (s == SIZE_E1);
        return {4'h0, a, l, ok && $countones(n ^ NDF_SET) <= 1, !ok};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [2:0] c,
                      input logic [8:0] idx, input logic [7:0] d);
        int n = 0;
        {wb_cyc_i, wb_stb_i} <= 2'b11;
        wb_we_i <= we;
        wb_adr_i <= {2'b00, c, idx, 2'b00};
        wb_dat_i <= {24'h00_0000, d};
        do
            @(posedge clock);
        while (wb_ack_o !== 1'b1 && n++ < 50);
        if (n > 50) error_cnt++;
        rdata = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clock);
    endtask
    task automatic rd(input logic [2:0] c, input logic [8:0] i,
                      input logic [7:0] x);
        wb(1'b0, c, i, 8'h00);
        chk(rdata[7:0], x);
    endtask
    task automatic send(input int k, input logic [2:0] c,
                        input logic [7:0] b, input int n);
        repeat (n) mdl.strobe(k, c, b, 8'h00);
    endtask
    task automatic close_out();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        close_out();
    end
    initial
    begin
        arst_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'h1;
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        ch = 3'($random(seed));
        rd(ch, IDX_CFG, CFG_RESET);
        rd(ch, IDX_PTR_MASK, MASK_RESET);
        wb(1'b1, ch, IDX_PATH_LIVE, 8'hFF);
        rd(ch, IDX_PATH_LIVE, 8'h00);
        rd(ch, 9'h1FF, 8'h00);
        $display("register test done");
        for (int i = 0; i < 6; i++)
        begin
            ch = 3'($random(seed));
            // expected label off 000/111 for clean recovery
            want = 3'(1 + $unsigned($random(seed)) % 6);
            lab = (i == 0) ? LABEL_AIS : (i == 1) ? LABEL_UNEQ
                                                  : 3'($random(seed));
            trans = 2'(i);
            e = path_exp(lab, want);
            wb(1'b1, ch, IDX_CFG, {3'h0, trans, want});
            wb(1'b1, ch, IDX_PATH_MASK, {8{i[0]}});
            send(0, ch, {4'h0, lab, 1'b0}, 4);
            rd(ch, IDX_PATH_LIVE, 8'h00);
            send(0, ch, {4'h0, lab, 1'b0}, 1);
            rd(ch, IDX_PATH_LIVE, e);
            rd(ch, IDX_PATH_LIVE, e);
            rd(ch + 3'h1, IDX_PATH_LIVE, 8'h00);
            if (i == 0) rd(ch, IDX_PATH_SEC, e);
            chk(irq, i[0] && trans != TRANS_FALL && e != 8'h00);
            rd(ch, IDX_PATH_LAT, trans != TRANS_FALL ? e : 8'h00);
            rd(ch, IDX_PATH_LAT, 8'h00);
            chk(irq, 1'b0);
            send(0, ch, {4'h0, want, 1'b0}, 5);
            rd(ch, IDX_PATH_LIVE, 8'h00);
            rd(ch, IDX_PATH_LAT, trans != TRANS_RISE ? e : 8'h00);
            if (i == 0) repeat (SEC - 7) @(posedge clock);
            if (i == 0) rd(ch, IDX_PATH_PSEC, e);
        end
        $display("label test done");
        for (int p = 0; p < 2; p++)
        begin
            wb(1'b1, ch, IDX_CFG, p[0] ? 8'h21 : 8'h01);
            for (int k = 0; k < 3; k++)
            begin
                send(1, ch, {5'h00, codes[k]}, p ? 9 : 4);
                rd(ch, IDX_PATH_LIVE, 8'h00);
                send(1, ch, {5'h00, codes[k]}, 1);
                rd(ch, IDX_PATH_LIVE, 8'h10 >> k);
                send(1, ch, 8'h00, p ? 10 : 5);
                rd(ch, IDX_PATH_LIVE, 8'h00);
            end
        end
        wb(1'b1, ch, IDX_CFG, 8'h41);
        send(0, ch, 8'h13, 4);
        rd(ch, IDX_PATH_LIVE, 8'h00);
        send(0, ch, 8'h13, 1);
        rd(ch, IDX_PATH_LIVE, 8'h05);
        send(0, ch, 8'h02, 5);
        rd(ch, IDX_PATH_LIVE, 8'h00);
        $display("remote defect test done");
        for (int i = 0; i < 12; i++)
        begin
            ch = 3'($random(seed));
            nib = (i < 6) ? nibs[i] : 4'($random(seed));
            sz = (i < 6) ? (i[0] ? SIZE_E1 : SIZE_DS1) : 2'($random(seed));
            pa = 8'($random(seed));
            pl = 8'($random(seed));
            ptr = 10'($unsigned($random(seed)) % 104);
            mdl.ptr_levels(pa, pl);
            mdl.strobe(2, ch, {nib, sz, ptr[9:8]}, ptr[7:0]);
            rd(ch, IDX_PTR_LIVE, ptr_exp(nib, sz, pa[ch], pl[ch]));
        end
        $display("pointer test done");
        wb(1'b1, ch, IDX_CFG, 8'h81);
        mdl.ptr_levels(8'h00, 8'h00);
        mdl.strobe(2, ch, {4'h6, SIZE_DS1, 2'h0}, 8'h00);
        mdl.fifo_event(ch, 1'($random(seed)));
        rd(ch, IDX_PTR_LIVE, 8'h10);
        chk(line_ais, 8'h01 << ch);
        send(0, ch, 8'h02, 1);
        chk(line_ais, 8'h01 << ch);
        send(0, ch, 8'h02, 1);
        rd(ch, IDX_PTR_LIVE, 8'h00);
        chk(line_ais, 8'h00);
        $display("fifo test done");
        close_out();
    end
endmodule
bind drop_side_vt_alarm_status drop_side_vt_alarm_props props_i (.*);
